/* pdu_top.v */
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "pdu_defines.vh"
module pdu_top #(
  parameter HALF_DUPLEX = 0
) (
  input wire CLK,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire RX_READY,
  input wire TX_READY,
  input wire [1:0] XFER_SIZE,
  output wire RX_STEP,
  output wire TX_STEP,
  output wire [31:0] RX_ADDR,
  output wire [31:0] TX_ADDR,
  input wire BUS_FAULT,
  output wire RX_BLOCK_DONE,
  output wire TX_BLOCK_DONE,
  output wire RX_ALL_DONE,
  output wire TX_ALL_DONE
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  wire wr_en; // apb write access phase
  wire rd_en; // apb read access phase
  wire [1:0] rdy_s; // synchronised peripheral ready pins
  wire fault_s; // synchronised bus error
  reg rx_requests_on_r; // rx request enable
  reg tx_requests_on_r; // tx request enable
  reg rx_ring_r; // rx circular mode
  reg tx_ring_r; // tx circular mode
  reg fault_r; // sticky bus fault
  reg rx_done_r; // rx block done flag
  reg tx_done_r; // tx block done flag
  reg rx_all_r; // rx all done flag
  reg tx_all_r; // tx all done flag
  reg rx_step_r; // rx move pulse
  reg tx_step_r; // tx move pulse
  reg rxz_d_r; // previous rx zero state
  reg txz_d_r; // previous tx zero state
  wire [31:0] rx_cptr, tx_cptr, rx_nptr, tx_nptr;
  wire [15:0] rx_ccnt, tx_ccnt, rx_ncnt, tx_ncnt;
  wire rx_busy, tx_busy, rx_z, tx_z, rx_za, tx_za;
  wire w_rx_current_address, w_rxcnt, w_tx_current_address, w_txcnt;
  wire w_rx_queued_address, w_rxncnt, w_tx_queued_address, w_txncnt;
  wire w_cmd;
  wire c_rxen, c_rxdis, c_txen, c_txdis;
  wire hd; // half duplex strap
  wire tx_ring_eff; // ring mode driving the tx engine
  wire rx_last; // step that takes the last item of the rx current count, with or without a reload
  wire tx_last; // step that takes the last item of the tx current count, with or without a reload
  ////////////////////////////////////////////////////////////////////////
  // apb handshake: zero wait states, never an error
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign hd = (HALF_DUPLEX != 0);
  ////////////////////////////////////////////////////////////////////////
  // write strobes; in half duplex tx addresses alias rx storage
  assign w_rx_current_address = wr_en && ((PADDR == `PDU_OFS_RX_CURRENT_ADDRESS) ||
                   (hd && PADDR == `PDU_OFS_TX_CURRENT_ADDRESS));
  assign w_rxcnt = wr_en && ((PADDR == `PDU_OFS_RXCNT) ||
                   (hd && PADDR == `PDU_OFS_TXCNT));
  assign w_rx_queued_address = wr_en && ((PADDR == `PDU_OFS_RX_QUEUED_ADDRESS) ||
                    (hd && PADDR == `PDU_OFS_TX_QUEUED_ADDRESS));
  assign w_rxncnt = wr_en && ((PADDR == `PDU_OFS_RXNCNT) ||
                    (hd && PADDR == `PDU_OFS_TXNCNT));
  assign w_tx_current_address = wr_en && !hd && (PADDR == `PDU_OFS_TX_CURRENT_ADDRESS);
  assign w_txcnt = wr_en && !hd && (PADDR == `PDU_OFS_TXCNT);
  assign w_tx_queued_address = wr_en && !hd && (PADDR == `PDU_OFS_TX_QUEUED_ADDRESS);
  assign w_txncnt = wr_en && !hd && (PADDR == `PDU_OFS_TXNCNT);
  assign w_cmd = wr_en && (PADDR == `PDU_OFS_CMD);
  assign c_rxen = w_cmd && PWDATA[`PDU_B_RXEN];
  assign c_rxdis = w_cmd && PWDATA[`PDU_B_RXDIS];
  assign c_txen = w_cmd && PWDATA[`PDU_B_TXEN];
  assign c_txdis = w_cmd && PWDATA[`PDU_B_TXDIS];
  ////////////////////////////////////////////////////////////////////////
  // ready and fault pins pass two flops before use
  pdu_sync #(.W(3)) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .din({BUS_FAULT, TX_READY, RX_READY}),
    .dout({fault_s, rdy_s})
  );
  ////////////////////////////////////////////////////////////////////////
  // channel engines; tx engine idle in half duplex
  pdu_chan u_rx (
    .clk(CLK),
    .nrst(NRST),
    .wr_cptr(w_rx_current_address),
    .wr_ccnt(w_rxcnt),
    .wr_nptr(w_rx_queued_address),
    .wr_ncnt(w_rxncnt),
    .wdata(PWDATA),
    .ring(rx_ring_r | (hd & tx_ring_r & tx_requests_on_r)),
    .step(rx_step_r | (hd & tx_step_r)),
    .size(XFER_SIZE),
    .cptr_r(rx_cptr),
    .ccnt_r(rx_ccnt),
    .nptr_r(rx_nptr),
    .ncnt_r(rx_ncnt),
    .busy(rx_busy),
    .zero_cur(rx_z),
    .zero_all(rx_za)
  );
  assign tx_ring_eff = tx_ring_r;
  pdu_chan u_tx (
    .clk(CLK),
    .nrst(NRST),
    .wr_cptr(w_tx_current_address),
    .wr_ccnt(w_txcnt),
    .wr_nptr(w_tx_queued_address),
    .wr_ncnt(w_txncnt),
    .wdata(PWDATA),
    .ring(tx_ring_eff),
    .step(tx_step_r & !hd),
    .size(XFER_SIZE),
    .cptr_r(tx_cptr),
    .ccnt_r(tx_ccnt),
    .nptr_r(tx_nptr),
    .ncnt_r(tx_ncnt),
    .busy(tx_busy),
    .zero_cur(tx_z),
    .zero_all(tx_za)
  );
  ////////////////////////////////////////////////////////////////////////
  // request enables and ring mode from command writes
  always @(posedge CLK) begin
    if (!NRST) begin
      rx_requests_on_r <= 1'b0;
      tx_requests_on_r <= 1'b0;
      rx_ring_r <= 1'b0;
      tx_ring_r <= 1'b0;
    end else begin
      if (hd) begin
        // enabling one direction clears the other, so rx and tx enables stay apart
        if (c_rxdis || c_txdis) begin
          rx_requests_on_r <= 1'b0;
          tx_requests_on_r <= 1'b0;
        end else if (c_rxen) begin
          rx_requests_on_r <= 1'b1;
          tx_requests_on_r <= 1'b0;
        end else if (c_txen) begin
          tx_requests_on_r <= 1'b1;
          rx_requests_on_r <= 1'b0;
        end
      end else begin
        if (c_rxdis) begin
          rx_requests_on_r <= 1'b0;
        end else if (c_rxen) begin
          rx_requests_on_r <= 1'b1;
        end
        if (c_txdis) begin
          tx_requests_on_r <= 1'b0;
        end else if (c_txen) begin
          tx_requests_on_r <= 1'b1;
        end
      end
      // disable wins when both are written together
      if (w_cmd && PWDATA[`PDU_B_RX_RING_OFF]) begin
        rx_ring_r <= 1'b0;
      end else if (w_cmd && PWDATA[`PDU_B_RX_RING_ON]) begin
        rx_ring_r <= 1'b1;
      end
      if (w_cmd && PWDATA[`PDU_B_TX_RING_OFF]) begin
        tx_ring_r <= 1'b0;
      end else if (w_cmd && PWDATA[`PDU_B_TX_RING_ON]) begin
        tx_ring_r <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // sticky fault: a new fault beats a clear in the same cycle
  always @(posedge CLK) begin
    if (!NRST) begin
      fault_r <= 1'b0;
    end else if (fault_s) begin
      fault_r <= 1'b1;
    end else if (w_cmd && PWDATA[`PDU_B_ERR]) begin
      fault_r <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // at most one move every other cycle per synchronised ready level while counts remain
  always @(posedge CLK) begin
    if (!NRST) begin
      rx_step_r <= 1'b0;
      tx_step_r <= 1'b0;
    end else begin
      rx_step_r <= rdy_s[0] && rx_requests_on_r && rx_busy &&
                   !rx_step_r;
      tx_step_r <= rdy_s[1] && tx_requests_on_r &&
                   (hd ? rx_busy : tx_busy) && !tx_step_r;
    end
  end
  assign RX_STEP = rx_step_r;
  assign TX_STEP = tx_step_r;
  assign RX_ADDR = rx_cptr;
  assign TX_ADDR = hd ? rx_cptr : tx_cptr;
  ////////////////////////////////////////////////////////////////////////
  // done flags set on reaching zero, cleared by nonzero count writes
  // a reload step never shows a zero count, so catch the last item here
  assign rx_last = (rx_step_r || (hd && tx_step_r)) &&
                   (rx_ccnt == 16'h0001);
  assign tx_last = hd ? rx_last : (tx_step_r && (tx_ccnt == 16'h0001));
  always @(posedge CLK) begin
    if (!NRST) begin
      rxz_d_r <= 1'b1;
      txz_d_r <= 1'b1;
      rx_done_r <= 1'b0;
      tx_done_r <= 1'b0;
      rx_all_r <= 1'b0;
      tx_all_r <= 1'b0;
    end else begin
      rxz_d_r <= rx_z;
      txz_d_r <= (hd ? rx_z : tx_z);
      if ((rx_z && !rxz_d_r) || rx_last) begin
        rx_done_r <= 1'b1;
      end else if ((w_rxcnt || w_rxncnt) && PWDATA[15:0] != 16'h0000) begin
        rx_done_r <= 1'b0;
      end
      if (rx_za && !rxz_d_r) begin
        rx_all_r <= 1'b1;
      end else if ((w_rxcnt || w_rxncnt) && PWDATA[15:0] != 16'h0000) begin
        rx_all_r <= 1'b0;
      end
      if (((hd ? rx_z : tx_z) && !txz_d_r) || tx_last) begin
        tx_done_r <= 1'b1;
      end else if ((w_txcnt || w_txncnt || (hd && (w_rxcnt || w_rxncnt)))
                   && PWDATA[15:0] != 16'h0000) begin
        tx_done_r <= 1'b0;
      end
      if ((hd ? rx_za : tx_za) && !txz_d_r) begin
        tx_all_r <= 1'b1;
      end else if ((w_txcnt || w_txncnt || (hd && (w_rxcnt || w_rxncnt)))
                   && PWDATA[15:0] != 16'h0000) begin
        tx_all_r <= 1'b0;
      end
    end
  end
  assign RX_BLOCK_DONE = rx_done_r;
  assign TX_BLOCK_DONE = tx_done_r;
  assign RX_ALL_DONE = rx_all_r;
  assign TX_ALL_DONE = tx_all_r;
  ////////////////////////////////////////////////////////////////////////
  // read mux; command register reads zero, unmapped reads zero
  always @* begin
    PRDATA = 32'h00000000;
    if (!rd_en) begin
      PRDATA = 32'h00000000;
    end else if (PADDR == `PDU_OFS_RX_CURRENT_ADDRESS ||
                 (hd && PADDR == `PDU_OFS_TX_CURRENT_ADDRESS)) begin
      PRDATA = rx_cptr;
    end else if (PADDR == `PDU_OFS_RXCNT ||
                 (hd && PADDR == `PDU_OFS_TXCNT)) begin
      PRDATA = {16'h0000, rx_ccnt};
    end else if (PADDR == `PDU_OFS_RX_QUEUED_ADDRESS ||
                 (hd && PADDR == `PDU_OFS_TX_QUEUED_ADDRESS)) begin
      PRDATA = rx_nptr;
    end else if (PADDR == `PDU_OFS_RXNCNT ||
                 (hd && PADDR == `PDU_OFS_TXNCNT)) begin
      PRDATA = {16'h0000, rx_ncnt};
    end else if (PADDR == `PDU_OFS_TX_CURRENT_ADDRESS) begin
      PRDATA = tx_cptr;
    end else if (PADDR == `PDU_OFS_TXCNT) begin
      PRDATA = {16'h0000, tx_ccnt};
    end else if (PADDR == `PDU_OFS_TX_QUEUED_ADDRESS) begin
      PRDATA = tx_nptr;
    end else if (PADDR == `PDU_OFS_TXNCNT) begin
      PRDATA = {16'h0000, tx_ncnt};
    end else if (PADDR == `PDU_OFS_STATE) begin
      PRDATA[`PDU_B_RXEN] = rx_requests_on_r;
      PRDATA[`PDU_B_TXEN] = tx_requests_on_r;
      PRDATA[`PDU_B_RX_RING_ON] = rx_ring_r;
      PRDATA[`PDU_B_TX_RING_ON] = tx_ring_r;
      PRDATA[`PDU_B_ERR] = fault_r;
    end else if (PADDR == `PDU_OFS_FLAGS) begin
      PRDATA[3:0] = {tx_all_r, rx_all_r, tx_done_r, rx_done_r};
    end
  end
endmodule

/* pdu_defines.vh */
`ifndef PDU_DEFINES_VH
`define PDU_DEFINES_VH
// register byte offsets
`define PDU_OFS_RX_CURRENT_ADDRESS 12'h000
`define PDU_OFS_RXCNT 12'h004
`define PDU_OFS_TX_CURRENT_ADDRESS 12'h008
`define PDU_OFS_TXCNT 12'h00c
`define PDU_OFS_RX_QUEUED_ADDRESS 12'h010
`define PDU_OFS_RXNCNT 12'h014
`define PDU_OFS_TX_QUEUED_ADDRESS 12'h018
`define PDU_OFS_TXNCNT 12'h01c
`define PDU_OFS_CMD 12'h020
`define PDU_OFS_STATE 12'h024
`define PDU_OFS_FLAGS 12'h028
// command and status bit positions
`define PDU_B_RXEN 0
`define PDU_B_RXDIS 1
`define PDU_B_TXEN 8
`define PDU_B_TXDIS 9
`define PDU_B_RX_RING_ON 16
`define PDU_B_RX_RING_OFF 17
`define PDU_B_TX_RING_ON 18
`define PDU_B_TX_RING_OFF 19
`define PDU_B_ERR 24
// transfer size codes
`define PDU_SZ_BYTE 2'h0
`define PDU_SZ_HALF 2'h1
`define PDU_SZ_WORD 2'h2
// reset value of every pointer; counts reset to zero directly
`define PDU_RST_VAL 32'h00000000
`endif

/* pdu_sync.v */
`timescale 1ns/100ps
`include "pdu_defines.vh"
// two-flop synchroniser, one per bit
module pdu_sync #(
  parameter W = 2
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] s1_r; // first stage, read only by second stage
  reg [W-1:0] s2_r; // second stage
  genvar i;
  ////////////////////////////////////////////////////////////////////////
  // per-bit two stage chain
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (!nrst) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
        end
      end
    end
  endgenerate
  assign dout = s2_r;
endmodule

/* pdu_chan.v */
`timescale 1ns/100ps
`include "pdu_defines.vh"
// one channel's pointer and count engine
module pdu_chan (
  input wire clk,
  input wire nrst,
  input wire wr_cptr,
  input wire wr_ccnt,
  input wire wr_nptr,
  input wire wr_ncnt,
  input wire [31:0] wdata,
  input wire ring,
  input wire step,
  input wire [1:0] size,
  output reg [31:0] cptr_r,
  output reg [15:0] ccnt_r,
  output reg [31:0] nptr_r,
  output reg [15:0] ncnt_r,
  output wire busy,
  output wire zero_cur,
  output wire zero_all
);
  reg [31:0] inc; // pointer stride in bytes
  ////////////////////////////////////////////////////////////////////////
  // stride from item size
  always @* begin
    inc = 32'h00000001;
    if (size == `PDU_SZ_HALF) begin
      inc = 32'h00000002;
    end else if (size == `PDU_SZ_WORD) begin
      inc = 32'h00000004;
    end
  end
  assign busy = (ccnt_r != 16'h0000);
  assign zero_cur = (ccnt_r == 16'h0000);
  assign zero_all = zero_cur && (ncnt_r == 16'h0000);
  ////////////////////////////////////////////////////////////////////////
  // software writes win over hardware updates of the same field
  always @(posedge clk) begin
    if (!nrst) begin
      cptr_r <= `PDU_RST_VAL;
      ccnt_r <= 16'h0000;
      nptr_r <= `PDU_RST_VAL;
      ncnt_r <= 16'h0000;
    end else begin
      if (step && busy) begin
        cptr_r <= cptr_r + inc;
        ccnt_r <= ccnt_r - 16'h0001;
        if (ccnt_r == 16'h0001 && ncnt_r != 16'h0000) begin
          // reload from queue when the current block ends
          cptr_r <= nptr_r;
          ccnt_r <= ncnt_r;
          if (!ring) begin
            nptr_r <= `PDU_RST_VAL; // ring keeps the queue
            ncnt_r <= 16'h0000;
          end
        end
      end
      if (wr_cptr) cptr_r <= wdata;
      if (wr_ccnt) ccnt_r <= wdata[15:0];
      if (wr_nptr) nptr_r <= wdata;
      if (wr_ncnt) ncnt_r <= wdata[15:0];
    end
  end
endmodule

/* pdu_assertions.sv */
`timescale 1ns/100ps
// pin-level watcher for the channel block
module pdu_checker (
  input wire CLK,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire RX_STEP,
  input wire TX_STEP,
  input wire [31:0] RX_ADDR,
  input wire RX_BLOCK_DONE,
  input wire TX_BLOCK_DONE,
  input wire RX_ALL_DONE,
  input wire TX_ALL_DONE
);
  wire wr = PSEL && PENABLE && PWRITE; // write committed at this edge
  wire rd = PSEL && PENABLE && !PWRITE; // read access phase
  wire cnt_at = PADDR[11:5] == 7'h0 && PADDR[2] == 1'b1; // any count reg
  wire cmd_wr = wr && PADDR == 12'h020; // command word written
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  //////////////////////////////////////////////////////////////////////////
  cnt_upper_zero_a: assert property (rd && cnt_at |-> PRDATA[31:16] == 16'h0)
    else $error("count upper half not zero");
  rx_step_single_a: assert property (RX_STEP |=> !RX_STEP)
    else $error("rx step longer than one cycle");
  tx_step_single_a: assert property (TX_STEP |=> !TX_STEP)
    else $error("tx step longer than one cycle");
  // the pointer only moves on a step or a software write
  rx_addr_hold_a: assert property (!RX_STEP && !wr |=> $stable(RX_ADDR))
    else $error("rx address moved without a step");
  rx_off_quiet_a: assert property (cmd_wr && PWDATA[1] |-> ##2 !RX_STEP [*4])
    else $error("rx stepped after disable");
  tx_off_quiet_a: assert property (cmd_wr && PWDATA[9] |-> ##2 !TX_STEP [*4])
    else $error("tx stepped after disable");
  rx_zero_halt_a: assert property (wr && PADDR == 12'h004 && PWDATA[15:0] == 16'h0
    |-> ##2 !RX_STEP [*4])
    else $error("rx stepped with zero count");
  rx_all_block_a: assert property (RX_ALL_DONE |-> RX_BLOCK_DONE)
    else $error("rx all done without block done");
  tx_all_block_a: assert property (TX_ALL_DONE |-> TX_BLOCK_DONE)
    else $error("tx all done without block done");
  // main scenarios reached
  cover property (RX_ALL_DONE);
  cover property (TX_STEP);
  cover property (cmd_wr);
endmodule

bind pdu_top pdu_checker chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .RX_STEP(RX_STEP), .TX_STEP(TX_STEP), .RX_ADDR(RX_ADDR),
  .RX_BLOCK_DONE(RX_BLOCK_DONE), .TX_BLOCK_DONE(TX_BLOCK_DONE),
  .RX_ALL_DONE(RX_ALL_DONE), .TX_ALL_DONE(TX_ALL_DONE));

/* pdu_peer.sv */
`timescale 1ns/100ps
// serial peripheral and bus matrix seen from the channel block
module pdu_peer (
  input wire clk,
  input wire rx_want,
  input wire tx_want,
  input wire slow,
  input wire fault_req,
  output wire rx_ready,
  output wire tx_ready,
  output reg bus_fault
);
  reg [2:0] ph_r = 3'h0; // pacing count for the slow peripheral
  initial bus_fault = 1'b0;
  // slow mode offers ready one cycle in eight to stretch the stream
  always @(posedge clk) ph_r <= ph_r + 3'h1;
  assign rx_ready = rx_want && (!slow || ph_r == 3'h7);
  assign tx_ready = tx_want && (!slow || ph_r == 3'h7);
  // matrix refuses an access and flags it for one cycle
  always @(posedge clk) bus_fault <= fault_req;
endmodule

/* tb.sv */
`timescale 1ns/100ps
module tb;
  logic CLK, NRST, PSEL, PENABLE, PWRITE, rx_want, tx_want, slow, fault_req;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, q, qh;
  wire [31:0] PRDATA_HD;
  logic [1:0] XFER_SIZE;
  wire [31:0] PRDATA, RX_ADDR, TX_ADDR;
  wire PREADY, PSLVERR, RX_READY, TX_READY, BUS_FAULT, RX_STEP, TX_STEP;
  wire RX_BLOCK_DONE, TX_BLOCK_DONE, RX_ALL_DONE, TX_ALL_DONE;
  int n_fail = 0, n_checks = 0, n_rx = 0, n_tx = 0, i, n;
  // rows: write address, write data, read address, expected read
  logic [87:0] rows [18] = '{
    {12'h000, 32'h2000_0000, 12'h000, 32'h2000_0000},
    {12'h004, 32'habcd_8001, 12'h004, 32'h0000_8001},
    {12'h008, 32'h2000_1000, 12'h008, 32'h2000_1000},
    {12'h00c, 32'h1234_0002, 12'h00c, 32'h0000_0002},
    {12'h010, 32'h2000_2000, 12'h010, 32'h2000_2000},
    {12'h014, 32'hffff_0003, 12'h014, 32'h0000_0003},
    {12'h018, 32'h2000_3000, 12'h018, 32'h2000_3000},
    {12'h01c, 32'h5555_0000, 12'h01c, 32'h0000_0000},
    {12'h024, 32'hffff_ffff, 12'h024, 32'h0000_0000},
    {12'h02c, 32'hffff_ffff, 12'h02c, 32'h0000_0000},
    {12'h020, 32'h0005_0101, 12'h020, 32'h0000_0000},
    {12'h020, 32'h0000_0000, 12'h024, 32'h0005_0101},
    {12'h020, 32'h0002_0002, 12'h024, 32'h0004_0100},
    {12'h020, 32'h0008_0200, 12'h024, 32'h0000_0000},
    {12'h020, 32'h0000_0003, 12'h024, 32'h0000_0000},
    {12'h020, 32'h0003_0000, 12'h024, 32'h0000_0000},
    {12'h020, 32'h0000_0100, 12'h024, 32'h0000_0100},
    {12'h020, 32'h0000_0200, 12'h024, 32'h0000_0000}};
  pdu_top dut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_READY(RX_READY),
    .TX_READY(TX_READY), .XFER_SIZE(XFER_SIZE), .RX_STEP(RX_STEP),
    .TX_STEP(TX_STEP), .RX_ADDR(RX_ADDR), .TX_ADDR(TX_ADDR),
    .BUS_FAULT(BUS_FAULT), .RX_BLOCK_DONE(RX_BLOCK_DONE),
    .TX_BLOCK_DONE(TX_BLOCK_DONE), .RX_ALL_DONE(RX_ALL_DONE),
    .TX_ALL_DONE(TX_ALL_DONE));
  // half duplex twin on the same bus, register behaviour only
  pdu_top #(.HALF_DUPLEX(1)) dut_hd (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA_HD), .PREADY(), .PSLVERR(), .RX_READY(1'b0),
    .TX_READY(1'b0), .XFER_SIZE(XFER_SIZE), .RX_STEP(), .TX_STEP(),
    .RX_ADDR(), .TX_ADDR(), .BUS_FAULT(1'b0), .RX_BLOCK_DONE(),
    .TX_BLOCK_DONE(), .RX_ALL_DONE(), .TX_ALL_DONE());
  pdu_peer peer (.clk(CLK), .rx_want(rx_want), .tx_want(tx_want),
    .slow(slow), .fault_req(fault_req), .rx_ready(RX_READY),
    .tx_ready(TX_READY), .bus_fault(BUS_FAULT));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // count moved items per direction
  always @(posedge CLK) begin
    if (RX_STEP === 1'b1) n_rx++;
    if (TX_STEP === 1'b1) n_tx++;
  end
  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 100);
    q = PRDATA;
    qh = PRDATA_HD;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 100) n_fail++;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // bounded wait for the all-done flag of one direction
  task automatic wt(input int s);
    n = 0;
    while ((s == 0 ? RX_ALL_DONE : TX_ALL_DONE) !== 1'b1 && n < 2000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 2000) n_fail++;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    conclude;
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {NRST, PSEL, PENABLE, PWRITE, rx_want, tx_want, slow, fault_req} = 8'h0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    XFER_SIZE = 2'h2;
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    for (i = 0; i < 11; i++) rd_chk(i * 4, 32'h0);
    $display("test reset done");
    for (i = 0; i < 18; i++) begin
      apb(1'b1, rows[i][87:76], rows[i][75:44]);
      rd_chk(rows[i][43:32], rows[i][31:0]);
    end
    $display("test table done");
    // one block then a queued block, for every item size
    rx_want <= 1'b1;
    for (i = 0; i < 3; i++) begin
      XFER_SIZE <= i[1:0];
      apb(1'b1, 12'h000, 32'h100);
      apb(1'b1, 12'h010, 32'h800);
      apb(1'b1, 12'h014, 32'h1);
      n_rx = 0;
      apb(1'b1, 12'h004, 32'h2);
      apb(1'b1, 12'h020, 32'h1);
      wt(0);
      chk("rx items", 32'h3, n_rx);
      chk("rx addr", 32'h800 + (32'h1 << i), RX_ADDR);
      rd_chk(12'h014, 32'h0);
      rd_chk(12'h010, 32'h0);
    end
    $display("test reload done");
    // ring mode keeps the queue after each reload
    apb(1'b1, 12'h020, 32'h0001_0000);
    apb(1'b1, 12'h010, 32'h200);
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b1, 12'h000, 32'h200);
    n_rx = 0;
    apb(1'b1, 12'h004, 32'h1);
    n = 0;
    while (n_rx < 4 && n < 200) begin
      @(posedge CLK);
      n++;
    end
    // stop requests first so a step in flight still sees ring mode
    apb(1'b1, 12'h020, 32'h2);
    chk("ring items", 32'h1, 32'(n_rx >= 4));
    chk("ring end", 32'h1, {31'h0, RX_BLOCK_DONE});
    rd_chk(12'h014, 32'h1);
    rd_chk(12'h010, 32'h200);
    apb(1'b1, 12'h020, 32'h0002_0000);
    $display("test ring done");
    // enabled channel with zero counts must stay still
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h020, 32'h1);
    n_rx = 0;
    repeat (20) @(posedge CLK);
    chk("rx idle items", 32'h0, n_rx);
    apb(1'b1, 12'h020, 32'h2);
    $display("test halt done");
    // transmit against a slow peripheral, counts left by the table
    slow <= 1'b1;
    tx_want <= 1'b1;
    n_tx = 0;
    apb(1'b1, 12'h020, 32'h100);
    wt(1);
    chk("tx items", 32'h2, n_tx);
    chk("tx addr", 32'h2000_1008, TX_ADDR);
    chk("tx block", 32'h1, {31'h0, TX_BLOCK_DONE});
    rd_chk(12'h00c, 32'h0);
    $display("test transmit done");
    // refused access sets the sticky fault until cleared
    fault_req <= 1'b1;
    @(posedge CLK);
    fault_req <= 1'b0;
    repeat (6) @(posedge CLK);
    apb(1'b0, 12'h024, 32'h0);
    chk("fault set", 32'h1, {31'h0, q[24]});
    apb(1'b1, 12'h020, 32'h0100_0000);
    apb(1'b0, 12'h024, 32'h0);
    chk("fault clear", 32'h0, {31'h0, q[24]});
    $display("test fault done");
    // half duplex twin: tx offsets alias rx storage, enables exclude
    apb(1'b1, 12'h008, 32'h3000);
    apb(1'b0, 12'h000, 32'h0);
    chk("hd ptr", 32'h3000, qh);
    apb(1'b1, 12'h01c, 32'h5);
    apb(1'b0, 12'h014, 32'h0);
    chk("hd qcnt", 32'h5, qh);
    apb(1'b1, 12'h020, 32'h100);
    apb(1'b1, 12'h020, 32'h1);
    apb(1'b0, 12'h024, 32'h0);
    chk("hd rx on", 32'h1, qh);
    apb(1'b1, 12'h020, 32'h200);
    apb(1'b0, 12'h024, 32'h0);
    chk("hd both off", 32'h0, qh);
    $display("test half duplex done");
    conclude;
  end
endmodule
